// ==== clocked_serial_port.sv ====
// Clocked serial port with its share of port three.
`timescale 1ns/100ps
`include "serial_port_params.svh"
`default_nettype none
// Function
// - Ready, clock, out, in on port three 7..4
// - Mode bits 1:0 select the clock source
// - Enable bit drives or receives clock pin
// - Enable clear leaves clock pin general I/O
// - Bit 3 puts ready_n on pin seven
// - Ready high while busy or dummy data
// - Write drops ready; next falling edge raises
// - Counter loads seven on shift register write
// - Fall presents bit; rise samples and shifts
// - Least significant bit goes first
// - Internal clock stops high, request set
// - External clock: request after eight counts
// - Request shares vector priority three
module clocked_serial_port
    import serial_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic timer3_ovf,
    input wire logic serial_req_clr,
    output logic serial_req_q,
    output logic [1:0] serial_vec_prio,
    input wire logic [7:0] port3_in,
    output logic [7:0] port3_out,
    output logic [7:0] port3_oe_n
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] mode_q;
    logic [7:0] shift_q;
    logic [7:0] p3_data_q;
    logic [7:0] p3_dir_q;
    logic [2:0] bit_cnt_q;
    logic [1:0] edge_cnt_q;
    logic half_en;
    logic [7:0] rx_q;
    logic rise_d1_q;
    logic rise_d2_q;
    logic done_q;
    logic sclk_q;
    logic sout_q;
    logic rdy_n_q;
    logic ext_clk_prev_q;
    logic [7:0] pin_s;
    xfer_state_type state_q;
    clk_src_type src;
    logic ser_en;
    logic rdy_en;
    logic internal_clk;
    logic wr_shift;
    logic fall_ev;
    logic rise_ev;
    logic last_bit;

    assign src = clk_src_type'(mode_q[`MODE_CLK_MSB:`MODE_CLK_LSB]);
    assign ser_en = mode_q[`MODE_SER_EN];
    assign rdy_en = mode_q[`MODE_RDY_EN];
    assign internal_clk = src[1];
    assign wr_shift = cpu_wr && cpu_addr == `SHIFT_REG_ADDR;
    assign last_bit = bit_cnt_q == 3'h0;

    pin_sync u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin_async(port3_in),
        .pin_sync_q(pin_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Half-period enable: phi/4 gives two system clocks per half, timer 3 halves.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            edge_cnt_q <= 2'h0;
        end else begin
            edge_cnt_q <= (edge_cnt_q == `PHI_DIV_HALF) ? 2'h0 : edge_cnt_q + 2'h1;
        end
    end

    always_comb begin
        case (src)
            clk_phi4: half_en = edge_cnt_q == `PHI_DIV_HALF;
            clk_timer3: half_en = timer3_ovf;
            default: half_en = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ext_clk_prev_q <= 1'b1;
        end else begin
            ext_clk_prev_q <= pin_s[`PIN_CLK];
        end
    end

    // Edge events; the external clock is only followed once synchronised.
    always_comb begin
        if (internal_clk) begin
            fall_ev = half_en && state_q == xfer_idle && !rdy_n_q;
            fall_ev = fall_ev || (half_en && state_q == xfer_high && !done_q);
            rise_ev = half_en && state_q == xfer_low;
        end else begin
            fall_ev = ser_en && ext_clk_prev_q && !pin_s[`PIN_CLK];
            rise_ev = ser_en && !ext_clk_prev_q && pin_s[`PIN_CLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= xfer_idle;
            sclk_q <= 1'b1;
        end else if (wr_shift) begin
            state_q <= xfer_idle;
            sclk_q <= 1'b1;
        end else begin
            case (state_q)
                xfer_idle: begin
                    if (fall_ev && internal_clk) begin
                        state_q <= xfer_low;
                        sclk_q <= 1'b0;
                    end
                end
                xfer_low: begin
                    if (rise_ev) begin
                        state_q <= xfer_high;
                        sclk_q <= 1'b1;
                    end
                end
                xfer_high: begin
                    if (!internal_clk) begin
                        state_q <= xfer_idle;
                    end else if (done_q) begin
                        state_q <= xfer_idle;
                    end else if (fall_ev) begin
                        state_q <= xfer_low;
                        sclk_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= xfer_idle;
                    sclk_q <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            shift_q <= `SHIFT_RESET;
            bit_cnt_q <= `BIT_COUNT_LOAD;
            sout_q <= 1'b1;
            done_q <= 1'b0;
        end else if (wr_shift) begin
            shift_q <= cpu_wdata;
            bit_cnt_q <= `BIT_COUNT_LOAD;
            done_q <= 1'b0;
        end else begin
            if (fall_ev) begin
                sout_q <= shift_q[0];
            end
            if (rise_ev) begin
                shift_q <= {shift_q[0], shift_q[7:1]};
                bit_cnt_q <= bit_cnt_q - 3'h1;
                done_q <= done_q || last_bit;
            end
        end
    end
    // The input is taken two cycles after the rise, because the pin reaches us late
    // through the synchroniser; that is still before the peer's next change.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rise_d1_q <= 1'b0;
            rise_d2_q <= 1'b0;
            rx_q <= `SHIFT_RESET;
        end else begin
            rise_d1_q <= rise_ev;
            rise_d2_q <= rise_d1_q;
            if (rise_d2_q) begin
                rx_q <= {pin_s[`PIN_SIN], rx_q[7:1]};
            end
        end
    end

    // Ready drops after the write and rises at the first falling clock edge.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdy_n_q <= 1'b1;
        end else if (wr_shift) begin
            rdy_n_q <= 1'b0;
        end else if (fall_ev) begin
            rdy_n_q <= 1'b1;
        end
    end

    // A new request beats a clear arriving in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            serial_req_q <= 1'b0;
            serial_vec_prio <= `SERIAL_VECTOR_PRIORITY;
        end else begin
            serial_vec_prio <= `SERIAL_VECTOR_PRIORITY;
            if (rise_d2_q && done_q) begin
                serial_req_q <= 1'b1;
            end else if (serial_req_clr) begin
                serial_req_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_q <= `MODE_RESET;
            p3_data_q <= `PORT3_RESET;
            p3_dir_q <= `PORT3_RESET;
        end else if (cpu_wr) begin
            case (cpu_addr)
                `MODE_REG_ADDR: mode_q <= cpu_wdata;
                `PORT3_DATA_ADDR: p3_data_q <= cpu_wdata;
                `PORT3_DIR_ADDR: p3_dir_q <= cpu_wdata;
                default: mode_q <= mode_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            case (cpu_addr)
                `MODE_REG_ADDR: cpu_rdata <= mode_q;
                `SHIFT_REG_ADDR: cpu_rdata <= rx_q;
                `PORT3_DATA_ADDR: cpu_rdata <= pin_s;
                `PORT3_DIR_ADDR: cpu_rdata <= p3_dir_q;
                default: cpu_rdata <= 8'h00;
            endcase
        end
    end

    // Open-drain pins: an enable low pulls the pin low; high releases it.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port3_out <= 8'h00;
            port3_oe_n <= 8'hff;
        end else begin
            port3_out <= 8'h00;
            port3_oe_n <= ~(p3_dir_q & ~p3_data_q);
            if (ser_en) begin
                port3_oe_n[`PIN_SOUT] <= sout_q;
                port3_oe_n[`PIN_CLK] <= internal_clk ? sclk_q : 1'b1;
                port3_oe_n[`PIN_SIN] <= 1'b1;
            end
            if (rdy_en) begin
                port3_oe_n[`PIN_RDY] <= rdy_n_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_count_load;
        @(posedge sys_clk) disable iff (sys_rst)
        wr_shift |=> bit_cnt_q == 3'h7;
    endproperty
    a_count_load: assert property (p_count_load) else $error("counter not seven");
    property p_ready_low;
        @(posedge sys_clk) disable iff (sys_rst)
        wr_shift |=> !rdy_n_q;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready not low");
    property p_ready_high;
        @(posedge sys_clk) disable iff (sys_rst)
        fall_ev && !wr_shift |=> rdy_n_q;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready not high");
    property p_lsb_first;
        @(posedge sys_clk) disable iff (sys_rst)
        fall_ev && !wr_shift |=> sout_q == $past(shift_q[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("wrong bit out");
    property p_shift_in;
        @(posedge sys_clk) disable iff (sys_rst)
        rise_d2_q |=> rx_q[7] == $past(pin_s[4]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("bad shift");
    property p_req_set;
        @(posedge sys_clk) disable iff (sys_rst)
        rise_d2_q && done_q |=> serial_req_q;
    endproperty
    a_req_set: assert property (p_req_set) else $error("request missing");
    property p_clk_stop_high;
        @(posedge sys_clk) disable iff (sys_rst)
        state_q == xfer_idle |-> sclk_q;
    endproperty
    a_clk_stop_high: assert property (p_clk_stop_high) else $error("clock low idle");
    property p_gpio_clk;
        @(posedge sys_clk) disable iff (sys_rst)
        !ser_en && !rdy_en |=> port3_oe_n == ~($past(p3_dir_q) & ~$past(p3_data_q));
    endproperty
    a_gpio_clk: assert property (p_gpio_clk) else $error("pins not gpio");
endmodule
`default_nettype wire

// ==== serial_port_params.svh ====
// Constants for the clocked serial port: offsets, fields, reset values and timing.
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
`define MODE_REG_ADDR 8'hf6
`define SHIFT_REG_ADDR 8'hf7
`define PORT3_DATA_ADDR 8'he6
`define PORT3_DIR_ADDR 8'he7
`define MODE_CLK_LSB 0
`define MODE_CLK_MSB 1
`define MODE_SER_EN 2
`define MODE_RDY_EN 3
`define MODE_RESET 8'h00
`define SHIFT_RESET 8'h00
`define PORT3_RESET 8'h00
`define BIT_COUNT_LOAD 3'h7
`define PIN_RDY 7
`define PIN_CLK 6
`define PIN_SOUT 5
`define PIN_SIN 4
`define PHI_DIV_HALF 2'h1
`define SERIAL_VECTOR_PRIORITY 2'h3
`endif

// ==== serial_port_pkg.sv ====
// Types shared by the clocked serial port.
package serial_port_pkg;
    typedef enum logic [1:0] {
        clk_ext0,
        clk_ext1,
        clk_timer3,
        clk_phi4
    } clk_src_type;
    typedef enum {
        xfer_idle,
        xfer_low,
        xfer_high
    } xfer_state_type;
endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for the port three pin inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] pin_async,
    output logic [7:0] pin_sync_q
);
    logic [7:0] stage1_q;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    stage1_q[i] <= 1'b1;
                    pin_sync_q[i] <= 1'b1;
                end else begin
                    stage1_q[i] <= pin_async[i];
                    pin_sync_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== serial_peer.sv ====
// Behavioural peer controller on the far side of the serial link.
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_pin,
    input wire logic sout_pin,
    input wire logic master_go,
    input wire logic [7:0] tx_byte,
    output logic sin_drv,
    output logic clk_drv,
    output logic [7:0] rx_byte
);
    logic [2:0] idx = 3'h0;
    initial begin
        sin_drv = 1'b1;
        clk_drv = 1'b1;
        rx_byte = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (sys_rst) idx <= 3'h0;
    end
    always @(negedge clk_pin) begin
        sin_drv <= tx_byte[idx];
    end
    // After the eighth bit the line is released and the pull-up takes it high.
    always @(posedge clk_pin) begin
        rx_byte <= {sout_pin, rx_byte[7:1]};
        idx <= idx + 3'h1;
        if (idx == 3'h7) sin_drv <= 1'b1;
    end
    // Eight slow symmetric periods, then the clock rests high.
    always @(posedge master_go) begin
        repeat (8) begin
            repeat (20) @(posedge sys_clk);
            clk_drv <= 1'b0;
            repeat (20) @(posedge sys_clk);
            clk_drv <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== clocked_serial_port_test.sv ====
// Self-checking bench for the clocked serial port and its peer.
`timescale 1ns/100ps
`include "serial_port_params.svh"
`default_nettype none
module clocked_serial_port_test
    import serial_port_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] cpu_addr = 8'h00;
    logic [7:0] cpu_wdata = 8'h00;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic timer3_ovf = 1'b0;
    logic serial_req_clr = 1'b0;
    logic master_go = 1'b0;
    logic t3_run = 1'b0;
    logic [1:0] t3_cnt = 2'h0;
    logic [7:0] peer_tx = 8'h00;
    logic [7:0] cpu_rdata, port3_out, port3_oe_n, pins, peer_rx;
    logic [1:0] prio;
    logic serial_req_q, sin_drv, clk_drv;
    int error_cnt = 0;
    int checked = 0;
    // Open-drain pins with pull-ups: a released pin follows the peer or rests high.
    assign pins = (port3_oe_n & {1'b1, clk_drv, 1'b1, sin_drv, 4'hf}) | (~port3_oe_n & port3_out);
    clocked_serial_port i_clocked_serial_port (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .timer3_ovf(timer3_ovf), .serial_req_clr(serial_req_clr),
        .serial_req_q(serial_req_q), .serial_vec_prio(prio), .port3_in(pins),
        .port3_out(port3_out), .port3_oe_n(port3_oe_n));
    serial_peer i_serial_peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_pin(pins[6]),
        .sout_pin(pins[5]), .master_go(master_go), .tx_byte(peer_tx), .sin_drv(sin_drv),
        .clk_drv(clk_drv), .rx_byte(peer_rx));
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        t3_cnt <= t3_cnt + 2'h1;
        timer3_ovf <= t3_run && (t3_cnt == 2'h0);
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge sys_clk);
        cpu_wr = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge sys_clk);
        cpu_rd = 1'b0;
        @(negedge sys_clk);
        d = cpu_rdata;
    endtask
    task automatic clr_req();
        serial_req_clr = 1'b1;
        @(negedge sys_clk);
        serial_req_clr = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic start(input logic [7:0] m, input logic [7:0] db, input logic [7:0] pb);
        peer_tx = pb;
        wr(`MODE_REG_ADDR, m);
        wr(`SHIFT_REG_ADDR, db);
    endtask
    // The wait is bounded so a transfer that never ends shows as a mismatch.
    task automatic finish(input logic [7:0] m, input logic [7:0] db, input logic [7:0] pb);
        logic [7:0] r;
        int n;
        n = 0;
        while (serial_req_q !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        chk("request", 8'h01, {7'h00, serial_req_q});
        chk("peer rx", db, peer_rx);
        rd(`SHIFT_REG_ADDR, r);
        chk("shift rd", pb, r);
        chk("clk pin", 8'h01, {7'h00, pins[6]});
        if (m[3]) chk("rdy pin", 8'h01, {7'h00, pins[7]});
        clr_req();
        chk("req clr", 8'h00, {7'h00, serial_req_q});
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] r;
        rd(`MODE_REG_ADDR, r);
        chk("mode rst", `MODE_RESET, r);
        chk("prio", 8'h03, {6'h00, prio});
        chk("oe_n rst", 8'hff, port3_oe_n);
        rd(8'h10, r);
        chk("unmapped", 8'h00, r);
        wr(`PORT3_DIR_ADDR, 8'h00);
        wr(`MODE_REG_ADDR, 8'h0f);
        rd(`MODE_REG_ADDR, r);
        chk("mode rw", 8'h0f, r);
    endtask
    task automatic t_disabled();
        wr(`MODE_REG_ADDR, 8'h03);
        wr(`SHIFT_REG_ADDR, 8'h5a);
        repeat (60) @(negedge sys_clk);
        chk("pins off", 8'h03, {6'h00, port3_oe_n[7:6]});
        clr_req();
    endtask
    task automatic t_phi4();
        start(8'h0f, 8'ha5, 8'h3c);
        finish(8'h0f, 8'ha5, 8'h3c);
    endtask
    // With no overflow pulses the clock cannot start, so ready stays low to be seen.
    task automatic t_timer3();
        start(8'h0e, 8'h81, 8'h7e);
        repeat (4) @(negedge sys_clk);
        chk("rdy low", 8'h00, {7'h00, pins[7]});
        chk("clk idle", 8'h01, {7'h00, pins[6]});
        t3_run = 1'b1;
        finish(8'h0e, 8'h81, 8'h7e);
        t3_run = 1'b0;
    endtask
    task automatic t_ext();
        logic [7:0] m;
        for (int i = 0; i < 2; i++) begin
            m = (i == 0) ? 8'h04 : 8'h05;
            start(m, 8'hc3 ^ m, 8'h96 ^ m);
            master_go = 1'b1;
            finish(m, 8'hc3 ^ m, 8'h96 ^ m);
            master_go = 1'b0;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(negedge sys_clk);
        t_reset();
        t_disabled();
        t_phi4();
        t_timer3();
        t_ext();
        summarize();
    end
    initial begin
        repeat (6000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
